/* core/tft_defines.vh */
`ifndef TFT_DEFINES_VH
`define TFT_DEFINES_VH

// ----------------------------------------
// Register indexes, byte address is four times the index
// ----------------------------------------
`define TFT_IDX_PA_LO 6'h16
`define TFT_IDX_PA_HI 6'h17
`define TFT_IDX_TX_LEAD 6'h18
`define TFT_IDX_BCN 6'h1A
`define TFT_IDX_NRM 6'h1B
`define TFT_IDX_GTS1 6'h1C
`define TFT_IDX_GTS2 6'h1D

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TFT_RST_PA_LO 8'h29
`define TFT_RST_PA_MSB 1'b0
`define TFT_RST_PA_SYM 4'h1
`define TFT_RST_TX_SYM 4'h2
`define TFT_RST_TX_HI 2'h0
`define TFT_RST_FIFO_EN 1'b1
`define TFT_RST_CTL 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TFT_TRIG_BIT 0
`define TFT_SEC_BIT 1
`define TFT_ACK_BIT 2
`define TFT_IND_BIT 3
`define TFT_FP_BIT 4
`define TFT_FIFO_EN_BIT 7
`define TFT_PA_MSB_BIT 0
`define TFT_PA_SYM_HI 4
`define TFT_PA_SYM_LO 1
`define TFT_TX_SYM_HI 5
`define TFT_TX_SYM_LO 2
`define TFT_TX_TICK_HI 1
`define TFT_TX_TICK_LO 0
`define TFT_RETRY_HI 7
`define TFT_RETRY_LO 6
`define TFT_SLOT_HI 5
`define TFT_SLOT_LO 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define TFT_CLK_PERIOD_NS 25
`define TFT_TICK_NS 50
`define TFT_SYMBOL_NS 16000
`define TFT_TICK_CYC ((`TFT_TICK_NS + `TFT_CLK_PERIOD_NS - 1) / `TFT_CLK_PERIOD_NS)
`define TFT_SYM_CYC ((`TFT_SYMBOL_NS + `TFT_CLK_PERIOD_NS - 1) / `TFT_CLK_PERIOD_NS)

`endif

/* core/tft_tx_ctrl.v */
// Function
// - PA lead ticks: nine bits, 50 ns units, low byte 0x16, msb 0x17 bit0.
// - PA lead symbols in 0x17 bits 4..1, reset one, minimum one; a write of zero is stored as zero.
// - TX lead symbols in 0x18 bits 5..2, reset two, software should use six.
// - TX lead ticks nine bits, upper two in 0x18 bits 1..0, reset 0x028.
// - Writing one to 0x1A bit0 sends beacon frame; hardware clears it.
// - 0x1A bit1 selects beacon security, reset zero.
// - Writing one to 0x1B bit0 sends normal frame; hardware clears it.
// - 0x1B bit2 requests acknowledgement with retransmission for normal frame.
// - 0x1B bit3 enables indirect normal transmission, coordinator only, reset off.
// - 0x1B bit4 reads frame-pending bit of last received acknowledgement.
// - 0x1B bit1 enables normal frame security, reset off.
// - Normal indirect, ack and security bits clear when the normal frame is launched.
// - 0x1C bits 7..6 take retry count; read returns retries used.
// - 0x1C bits 5..3 hold GTS1 slot number.
// - 0x1C bit2 requests acknowledgement with retransmission for GTS1.
// - 0x1C bit1 enables GTS1 security, reset zero.
// - Writing one to 0x1C bit0 sends GTS1 frame; hardware clears it.
// - 0x1D gives GTS2 retry and slot fields like 0x1C.
// - 0x1D ack, security and trigger bits as for GTS1.
`timescale 1ns/100ps
`include "tft_defines.vh"

module tft_tx_ctrl (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [6:0] tx_lead_ticks_low,
  input wire ack_received,
  input wire ack_frame_pending,
  input wire [1:0] gts_sent_ok,
  input wire [3:0] gts_retries_used,
  input wire tx_done,
  output reg [3:0] launch_fifo,
  output reg launch_security,
  output reg launch_ack_request,
  output reg launch_indirect,
  output reg [1:0] launch_retry_count,
  output reg [2:0] launch_slot_number,
  output reg packet_start,
  output reg pa_enable,
  output reg tx_enable,
  output wire tx_fifo_enable
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LEAD = 3'b010;
  localparam [2:0] ST_SEND = 3'b100;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function reg_hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  function [15:0] lead_cyc;
    input [3:0] sym;
    input [8:0] tick;
    reg [31:0] tmp;
    begin
      tmp = sym * `TFT_SYM_CYC + tick * `TFT_TICK_CYC;
      lead_cyc = tmp[15:0];
    end
  endfunction

  // ----------------------------------------
  // Bus slave handshake
  // ----------------------------------------
  reg ack_ff;
  wire req;
  wire wr_en;
  wire [7:0] wd;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign wr_en = avs_write & ack_ff & avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ----------------------------------------
  // Lead time and FIFO enable registers
  // ----------------------------------------
  reg [7:0] pa_lo_ff;
  reg pa_msb_ff;
  reg [3:0] pa_sym_ff;
  reg [3:0] tx_sym_ff;
  reg [1:0] tx_hi_ff;
  reg fifo_en_ff;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pa_lo_ff <= `TFT_RST_PA_LO;
      pa_msb_ff <= `TFT_RST_PA_MSB;
      pa_sym_ff <= `TFT_RST_PA_SYM;
      tx_sym_ff <= `TFT_RST_TX_SYM;
      tx_hi_ff <= `TFT_RST_TX_HI;
      fifo_en_ff <= `TFT_RST_FIFO_EN;
    end else if (clk_en) begin
      if (wr_en && reg_hit(avs_address, `TFT_IDX_PA_LO)) begin
        pa_lo_ff <= wd;
      end
      if (wr_en && reg_hit(avs_address, `TFT_IDX_PA_HI)) begin
        pa_msb_ff <= wd[`TFT_PA_MSB_BIT];
        pa_sym_ff <= wd[`TFT_PA_SYM_HI:`TFT_PA_SYM_LO];
      end
      if (wr_en && reg_hit(avs_address, `TFT_IDX_TX_LEAD)) begin
        tx_sym_ff <= wd[`TFT_TX_SYM_HI:`TFT_TX_SYM_LO];
        tx_hi_ff <= wd[`TFT_TX_TICK_HI:`TFT_TX_TICK_LO];
        fifo_en_ff <= wd[`TFT_FIFO_EN_BIT];
      end
    end
  end

  assign tx_fifo_enable = fifo_en_ff;

  // ----------------------------------------
  // Launch arbitration
  // ----------------------------------------
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg bcn_trig_ff;
  reg nrm_trig_ff;
  wire [15:0] gts_ctl;
  wire [3:0] pend;
  reg [3:0] nxt_launch;
  wire can_launch;

  assign pend = {gts_ctl[8 + `TFT_TRIG_BIT], gts_ctl[`TFT_TRIG_BIT], nrm_trig_ff, bcn_trig_ff};
  assign can_launch = (state_ff == ST_IDLE) & fifo_en_ff;

  // Beacon first, then normal, then GTS1, then GTS2
  always @* begin
    nxt_launch = 4'h0;
    if (can_launch) begin
      if (pend[0]) begin
        nxt_launch = 4'h1;
      end else if (pend[1]) begin
        nxt_launch = 4'h2;
      end else if (pend[2]) begin
        nxt_launch = 4'h4;
      end else if (pend[3]) begin
        nxt_launch = 4'h8;
      end
    end
  end

  // ----------------------------------------
  // Beacon and normal FIFO control
  // ----------------------------------------
  reg bcn_sec_ff;
  reg nrm_sec_ff;
  reg nrm_ack_ff;
  reg nrm_ind_ff;
  reg fp_ff;
  wire wr_bcn;
  wire wr_nrm;

  assign wr_bcn = wr_en & reg_hit(avs_address, `TFT_IDX_BCN);
  assign wr_nrm = wr_en & reg_hit(avs_address, `TFT_IDX_NRM);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bcn_sec_ff <= 1'b0;
      bcn_trig_ff <= 1'b0;
      nrm_sec_ff <= 1'b0;
      nrm_ack_ff <= 1'b0;
      nrm_ind_ff <= 1'b0;
      nrm_trig_ff <= 1'b0;
      fp_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_bcn) begin
        bcn_sec_ff <= wd[`TFT_SEC_BIT];
      end
      bcn_trig_ff <= (bcn_trig_ff & ~nxt_launch[0]) | (wr_bcn & wd[`TFT_TRIG_BIT]);
      nrm_trig_ff <= (nrm_trig_ff & ~nxt_launch[1]) | (wr_nrm & wd[`TFT_TRIG_BIT]);
      if (wr_nrm) begin
        nrm_sec_ff <= wd[`TFT_SEC_BIT];
        nrm_ack_ff <= wd[`TFT_ACK_BIT];
        nrm_ind_ff <= wd[`TFT_IND_BIT];
      end else if (nxt_launch[1]) begin
        nrm_sec_ff <= 1'b0;
        nrm_ack_ff <= 1'b0;
        nrm_ind_ff <= 1'b0;
      end
      if (ack_received) begin
        fp_ff <= ack_frame_pending;
      end
    end
  end

  // ----------------------------------------
  // GTS1 and GTS2 FIFO control
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_gts
      reg [7:0] ctl_ff;
      wire wr_g;
      assign wr_g = wr_en & reg_hit(avs_address, (gi == 0) ? `TFT_IDX_GTS1 : `TFT_IDX_GTS2);
      assign gts_ctl[8 * gi + 7:8 * gi] = ctl_ff;

      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ctl_ff <= `TFT_RST_CTL;
        end else if (clk_en) begin
          if (gts_sent_ok[gi]) begin
            ctl_ff[`TFT_RETRY_HI:`TFT_RETRY_LO] <= gts_retries_used[2 * gi + 1:2 * gi];
          end else if (wr_g) begin
            ctl_ff[`TFT_RETRY_HI:`TFT_RETRY_LO] <= wd[`TFT_RETRY_HI:`TFT_RETRY_LO];
          end
          if (wr_g) begin
            ctl_ff[`TFT_SLOT_HI:`TFT_SLOT_LO] <= wd[`TFT_SLOT_HI:`TFT_SLOT_LO];
            ctl_ff[`TFT_ACK_BIT] <= wd[`TFT_ACK_BIT];
            ctl_ff[`TFT_SEC_BIT] <= wd[`TFT_SEC_BIT];
          end
          ctl_ff[`TFT_TRIG_BIT] <= (ctl_ff[`TFT_TRIG_BIT] & ~nxt_launch[2 + gi])
            | (wr_g & wd[`TFT_TRIG_BIT]);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (reg_hit(avs_address, `TFT_IDX_PA_LO)) begin
      rd_byte = pa_lo_ff;
    end else if (reg_hit(avs_address, `TFT_IDX_PA_HI)) begin
      rd_byte = {3'h0, pa_sym_ff, pa_msb_ff};
    end else if (reg_hit(avs_address, `TFT_IDX_TX_LEAD)) begin
      rd_byte = {fifo_en_ff, 1'b0, tx_sym_ff, tx_hi_ff};
    end else if (reg_hit(avs_address, `TFT_IDX_BCN)) begin
      rd_byte = {6'h00, bcn_sec_ff, bcn_trig_ff};
    end else if (reg_hit(avs_address, `TFT_IDX_NRM)) begin
      rd_byte = {3'h0, fp_ff, nrm_ind_ff, nrm_ack_ff, nrm_sec_ff, nrm_trig_ff};
    end else if (reg_hit(avs_address, `TFT_IDX_GTS1)) begin
      rd_byte = gts_ctl[7:0];
    end else if (reg_hit(avs_address, `TFT_IDX_GTS2)) begin
      rd_byte = gts_ctl[15:8];
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      if (avs_read & ~ack_ff) begin
        avs_readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Launch configuration capture
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      launch_fifo <= 4'h0;
      launch_security <= 1'b0;
      launch_ack_request <= 1'b0;
      launch_indirect <= 1'b0;
      launch_retry_count <= 2'h0;
      launch_slot_number <= 3'h0;
    end else if (clk_en) begin
      launch_fifo <= nxt_launch;
      if (nxt_launch[0]) begin
        launch_security <= bcn_sec_ff;
        launch_ack_request <= 1'b0;
        launch_indirect <= 1'b0;
        launch_retry_count <= 2'h0;
        launch_slot_number <= 3'h0;
      end else if (nxt_launch[1]) begin
        launch_security <= nrm_sec_ff;
        launch_ack_request <= nrm_ack_ff;
        launch_indirect <= nrm_ind_ff;
        launch_retry_count <= 2'h0;
        launch_slot_number <= 3'h0;
      end else if (nxt_launch[2]) begin
        launch_security <= gts_ctl[`TFT_SEC_BIT];
        launch_ack_request <= gts_ctl[`TFT_ACK_BIT];
        launch_indirect <= 1'b0;
        launch_retry_count <= gts_ctl[`TFT_RETRY_HI:`TFT_RETRY_LO];
        launch_slot_number <= gts_ctl[`TFT_SLOT_HI:`TFT_SLOT_LO];
      end else if (nxt_launch[3]) begin
        launch_security <= gts_ctl[8 + `TFT_SEC_BIT];
        launch_ack_request <= gts_ctl[8 + `TFT_ACK_BIT];
        launch_indirect <= 1'b0;
        launch_retry_count <= gts_ctl[8 + `TFT_RETRY_HI:8 + `TFT_RETRY_LO];
        launch_slot_number <= gts_ctl[8 + `TFT_SLOT_HI:8 + `TFT_SLOT_LO];
      end
    end
  end

  // ----------------------------------------
  // Lead time sequencer
  // ----------------------------------------
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  wire [15:0] tx_lead;
  wire [15:0] pa_lead;

  // lead time from symbols and ticks
  assign tx_lead = lead_cyc(tx_sym_ff, {tx_hi_ff, tx_lead_ticks_low});
  assign pa_lead = lead_cyc(pa_sym_ff, {pa_msb_ff, pa_lo_ff});

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (nxt_launch != 4'h0) begin
          nxt_state = ST_LEAD;
          nxt_cnt = (tx_lead == 16'h0000) ? 16'h0001 : tx_lead;
        end
      end
      ST_LEAD: begin
        if (cnt_ff <= 16'h0001) begin
          nxt_state = ST_SEND;
          nxt_cnt = 16'h0000;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      ST_SEND: begin
        if (tx_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt = 16'h0000;
      end
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      packet_start <= 1'b0;
      pa_enable <= 1'b0;
      tx_enable <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      packet_start <= (state_ff == ST_LEAD) && (nxt_state == ST_SEND);
      tx_enable <= (nxt_state == ST_LEAD) || (nxt_state == ST_SEND);
      pa_enable <= ((nxt_state == ST_LEAD) && (nxt_cnt <= pa_lead))
        || (nxt_state == ST_SEND);
    end
  end

endmodule

/* sim/tft_tx_ctrl_assertions.sv */
`timescale 1ns/100ps
module tft_tx_ctrl_chk (
  input logic ref_clk,
  input logic rst,
  input logic clk_en,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic [31:0] avs_readdata,
  input logic [3:0] launch_fifo,
  input logic packet_start,
  input logic pa_enable,
  input logic tx_enable,
  input logic tx_done,
  input logic tx_fifo_enable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low on a fresh request");
  wait_answer_a: assert property ($rose(avs_read || avs_write) && clk_en |=> !avs_waitrequest)
    else $error("waitrequest not released one cycle after request");
  rdata_upper_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("readdata upper bits not zero");

  // ----------------------------------------
  // Launch sequencing
  // ----------------------------------------
  launch_pulse_a: assert property (launch_fifo != 4'h0 |-> $onehot(launch_fifo) ##1 launch_fifo == 4'h0)
    else $error("launch not a one-hot single pulse");
  launch_idle_a: assert property (launch_fifo != 4'h0 |-> tx_enable && $past(tx_fifo_enable) && !$past(tx_enable))
    else $error("launch while busy or fifo disabled, or without tx enable");
  packet_en_a: assert property (packet_start |-> tx_enable && pa_enable ##1 !packet_start)
    else $error("packet start without both enables or longer than one cycle");
  tx_drop_a: assert property ($fell(tx_enable) |-> $past(tx_done))
    else $error("tx enable dropped without tx done");
  tx_hold_a: assert property (tx_enable && !tx_done && clk_en |=> tx_enable)
    else $error("tx enable lost before tx done");
  pa_rise_a: assert property ($rose(pa_enable) |-> tx_enable)
    else $error("pa enable rose outside a transmission");

  cover property (launch_fifo[0]);
  cover property (launch_fifo[3]);
  cover property (packet_start);
  cover property ($fell(tx_enable));
endmodule

bind tft_tx_ctrl tft_tx_ctrl_chk tft_tx_ctrl_chk_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .launch_fifo(launch_fifo), .packet_start(packet_start),
  .pa_enable(pa_enable), .tx_enable(tx_enable), .tx_done(tx_done),
  .tx_fifo_enable(tx_fifo_enable));

/* sim/tft_tb.sv */
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [6:0] tx_lead_ticks_low = 7'h05;
  logic ack_received = 1'b0;
  logic ack_frame_pending = 1'b0;
  logic [1:0] gts_sent_ok = 2'h0;
  logic [3:0] gts_retries_used = 4'h7;
  logic tx_done = 1'b0;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire [3:0] launch_fifo;
  wire [1:0] launch_retry_count;
  wire [2:0] launch_slot_number;
  wire avs_waitrequest, launch_security, launch_ack_request, launch_indirect;
  wire packet_start, pa_enable, tx_enable, tx_fifo_enable;
  int err_count = 0;
  int checks_done = 0;

  tft_tx_ctrl tft_tx_ctrl_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_lead_ticks_low(tx_lead_ticks_low),
    .ack_received(ack_received), .ack_frame_pending(ack_frame_pending),
    .gts_sent_ok(gts_sent_ok), .gts_retries_used(gts_retries_used), .tx_done(tx_done),
    .launch_fifo(launch_fifo), .launch_security(launch_security),
    .launch_ack_request(launch_ack_request), .launch_indirect(launch_indirect),
    .launch_retry_count(launch_retry_count), .launch_slot_number(launch_slot_number),
    .packet_start(packet_start), .pa_enable(pa_enable), .tx_enable(tx_enable),
    .tx_fifo_enable(tx_fifo_enable));

  always #12.5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  // Entered just after a rising edge; returns one idle cycle after the accept edge
  task automatic bus(input logic rd, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    chk(n < 50, 1'b1, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00);
    chk(q, {24'h0, exp}, "register read");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] rv [7] = '{8'h29, 8'h02, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++)
      rd(6'(8'h16 + i + (i > 2)), rv[i]);
    chk(tx_fifo_enable, 1'b1, "fifo enable at reset");
    bus(1'b0, 6'h19, 8'hFF);
    rd(6'h19, 8'h00);
  endtask

  // Lead times: pa 1 symbol + 0 ticks, tx 1 symbol + 5 ticks
  task automatic t_setup();
    bus(1'b0, 6'h16, 8'h00);
    rd(6'h16, 8'h00);
    bus(1'b0, 6'h17, 8'h02);
    rd(6'h17, 8'h02);
    bus(1'b0, 6'h18, 8'h84);
    rd(6'h18, 8'h84);
  endtask

  task automatic t_fifo(input int k);
    logic [7:0] wd [4] = '{8'h03, 8'h0F, 8'h6B, 8'h97};
    logic [7:0] rb [4] = '{8'h02, 8'h00, 8'hEA, 8'h56};
    int n;
    int pa_n;
    n = 0;
    pa_n = 0;
    fork
      bus(1'b0, 6'(8'h1A + k), wd[k]);
      begin
        do begin
          @(negedge ref_clk);
          n++;
        end while (launch_fifo === 4'h0 && n < 20);
        chk(launch_fifo, 4'h1 << k, "launch fifo");
        chk({tx_enable, pa_enable, launch_security}, {2'b10, wd[k][1]}, "launch state");
        chk({launch_ack_request, launch_indirect}, {wd[k][2] && k > 0, wd[k][3] && k == 1}, "ack");
        if (k > 1)
          chk({launch_retry_count, launch_slot_number}, wd[k][7:3], "gts fields");
        n = 0;
        do begin
          @(negedge ref_clk);
          n++;
          if (pa_enable === 1'b1 && pa_n == 0)
            pa_n = n;
        end while (packet_start !== 1'b1 && n < 2000);
      end
    join
    chk(n >= 649 && n <= 651, 1'b1, "tx lead length");
    chk(pa_n >= 9 && pa_n <= 11, 1'b1, "pa lead length");
    @(posedge ref_clk);
    tx_done <= 1'b1;
    gts_sent_ok <= (k > 1) ? 2'(k - 1) : 2'h0;
    @(posedge ref_clk);
    tx_done <= 1'b0;
    gts_sent_ok <= 2'h0;
    @(negedge ref_clk);
    chk(tx_enable, 1'b0, "tx enable after done");
    @(posedge ref_clk);
    rd(6'(8'h1A + k), rb[k]);
  endtask

  task automatic t_fp();
    clk_en <= 1'b0;
    ack_received <= 1'b1;
    ack_frame_pending <= 1'b1;
    @(posedge ref_clk);
    clk_en <= 1'b1;
    ack_received <= 1'b0;
    ack_frame_pending <= 1'b0;
    @(posedge ref_clk);
    rd(6'h1B, 8'h00);
    ack_received <= 1'b1;
    ack_frame_pending <= 1'b1;
    @(posedge ref_clk);
    ack_received <= 1'b0;
    ack_frame_pending <= 1'b0;
    @(posedge ref_clk);
    rd(6'h1B, 8'h10);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_setup();
    for (int k = 0; k < 4; k++)
      t_fifo(k);
    t_fp();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end
endmodule
